/* gpio_pin_defs.vh */
/*
 * Shared constants for the port E/F/G pin control block: register byte
 * offsets, reset values, AXI4-Lite response codes and pin positions.
 * Assumes it is included by bare name from every design file that needs it.
 */
`ifndef GPIO_PIN_DEFS_VH
`define GPIO_PIN_DEFS_VH

`define ADDR_W              8
`define DATA_W              32
`define PORT_W              8

`define OFF_PE_DIRECTION    8'h00
`define OFF_PE_OUTPUT_VALUE 8'h04
`define OFF_PE_DRIVER_TYPE  8'h08
`define OFF_PF_DIRECTION    8'h0c
`define OFF_PF_OUTPUT_VALUE 8'h10
`define OFF_PF_DRIVER_TYPE  8'h14
`define OFF_PG_DIRECTION    8'h18
`define OFF_PG_OUTPUT_VALUE 8'h1c

`define RST_BYTE            8'h00
`define RST_WORD            32'h0000_0000
`define SEL_NONE            4'h0

`define RESP_OKAY           2'b00
`define RESP_SLVERR         2'b10

`define PF_TIMER_A_OUT_BIT  2
`define PF_TIMER_B_OUT_BIT  3
`define PF_TIMER_A_IN_BIT   0
`define PF_TIMER_B_IN_BIT   1

`define PG_I2C_B_CLOCK_BIT  7
`define PG_I2C_B_DATA_BIT   6
`define PG_I2C_A_CLOCK_BIT  5
`define PG_I2C_A_DATA_BIT   4

`endif

/* pin_driver_port.v */
/*
 * Output driver and pull-up logic for one 8-bit port (E or F).
 * Assumes direction, output value and driver type come from registers in
 * the same clock domain, and that a timer takeover mask arrives per pin.
 */
`timescale 1ns/1ps
`include "gpio_pin_defs.vh"

module pin_driver_port (
	input  wire                 aclk,
	input  wire                 aresetn,
	input  wire                 hw_standby,
	input  wire [`PORT_W-1:0]   direction,
	input  wire [`PORT_W-1:0]   output_value,
	input  wire [`PORT_W-1:0]   driver_type,
	input  wire [`PORT_W-1:0]   timer_take,
	input  wire [`PORT_W-1:0]   timer_value,
	output reg  [`PORT_W-1:0]   pin_out,
	output reg  [`PORT_W-1:0]   pin_oe,
	output reg  [`PORT_W-1:0]   pull_on
);

	wire [`PORT_W-1:0] eff_dir;
	wire [`PORT_W-1:0] eff_val;

	// A timer that owns a pin forces output mode
	assign eff_dir = timer_take | direction;
	assign eff_val = (timer_take & timer_value) | (~timer_take & output_value);

	always @(posedge aclk) begin
		if (!aresetn) begin
			pin_out <= `RST_BYTE;
			pin_oe  <= `RST_BYTE;
			pull_on <= `RST_BYTE; // [R8]
		end else begin
			pin_out <= eff_val; // [R5]
			// Open drain drops the high side, so a 1 floats the pin [R3] [R4] [R5] [R6]
			pin_oe  <= eff_dir & (~eff_val | ~driver_type);
			// Standby kills pull-ups; only an input with value 1 gets one [R7] [R8]
			pull_on <= {`PORT_W{~hw_standby}} & ~direction & output_value & ~eff_dir;
		end
	end

endmodule // pin_driver_port

/* port_g_driver.v */
/*
 * Output driver logic for port G: push-pull general-purpose outputs and
 * open-drain drive on pins handed to the I2C channels.
 * Assumes the I2C takeover mask and drive-low requests are synchronous.
 */
`timescale 1ns/1ps
`include "gpio_pin_defs.vh"

module port_g_driver (
	input  wire                 aclk,
	input  wire                 aresetn,
	input  wire [`PORT_W-1:0]   direction,
	input  wire [`PORT_W-1:0]   output_value,
	input  wire [`PORT_W-1:0]   i2c_take,
	input  wire [`PORT_W-1:0]   i2c_low,
	output reg  [`PORT_W-1:0]   pin_out,
	output reg  [`PORT_W-1:0]   pin_oe
);

	always @(posedge aclk) begin
		if (!aresetn) begin
			pin_out <= `RST_BYTE;
			pin_oe  <= `RST_BYTE;
		end else begin
			// I2C pins only ever pull low; the bus pull-up makes the high [R10]
			pin_out <= ~i2c_take & output_value;
			pin_oe  <= (i2c_take & i2c_low) | (~i2c_take & direction); // [R9] [R11]
		end
	end

endmodule // port_g_driver

/* gpio_drive_pullup_direction.v */
/*
 * Pin control for ports E and F (direction, output value, driver type,
 * pull-ups, port F timer takeover) and port G (direction, output value, I2C
 * takeover), with an AXI4-Lite register slave.
 * Assumes pin inputs, timer signals and standby are synchronous to aclk.
 */
// The placing of the registers and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ps
`include "gpio_pin_defs.vh"

// How it works
// [R1] Nonzero timer select makes pin timer output
// [R2] Port F bits 1,0 follow direction; timer input always
// [R3] Per-bit driver type selects output style
// [R4] Type 0 push-pull, type 1 open-drain
// [R5] Direction 0 drivers off; value 0 drives low
// [R6] Driver type also applies to timer outputs
// [R7] Pull-up only for input with value 1
// [R8] Pull-ups off in reset and hardware standby
// [R9] Port G: eight pins, some shared with I2C
// [R10] Port G push-pull; I2C pins open-drain
// [R11] Port G direction bit per pin, resets 0
// [R12] Direction write-only; read returns pin levels
// [R13] Output value registers always readable and writable
// [R14] Driver-type bits reset to push-pull
// [R15] Software shadows the write-only direction register
module gpio_drive_pullup_direction (
	input  wire                 aclk,
	input  wire                 aresetn,
	input  wire [`ADDR_W-1:0]   s_axi_awaddr,
	input  wire [2:0]           s_axi_awprot,
	input  wire                 s_axi_awvalid,
	output reg                  s_axi_awready,
	input  wire [`DATA_W-1:0]   s_axi_wdata,
	input  wire [3:0]           s_axi_wstrb,
	input  wire                 s_axi_wvalid,
	output reg                  s_axi_wready,
	output reg  [1:0]           s_axi_bresp,
	output reg                  s_axi_bvalid,
	input  wire                 s_axi_bready,
	input  wire [`ADDR_W-1:0]   s_axi_araddr,
	input  wire [2:0]           s_axi_arprot,
	input  wire                 s_axi_arvalid,
	output reg                  s_axi_arready,
	output reg  [`DATA_W-1:0]   s_axi_rdata,
	output reg  [1:0]           s_axi_rresp,
	output reg                  s_axi_rvalid,
	input  wire                 s_axi_rready,
	input  wire                 hw_standby,
	input  wire [`PORT_W-1:0]   pe_pin_in,
	output wire [`PORT_W-1:0]   pe_pin_out,
	output wire [`PORT_W-1:0]   pe_pin_oe,
	output wire [`PORT_W-1:0]   pe_pullup,
	input  wire [`PORT_W-1:0]   pf_pin_in,
	output wire [`PORT_W-1:0]   pf_pin_out,
	output wire [`PORT_W-1:0]   pf_pin_oe,
	output wire [`PORT_W-1:0]   pf_pullup,
	input  wire [`PORT_W-1:0]   pg_pin_in,
	output wire [`PORT_W-1:0]   pg_pin_out,
	output wire [`PORT_W-1:0]   pg_pin_oe,
	input  wire [3:0]           timer_a_output_select,
	input  wire [3:0]           timer_b_output_select,
	input  wire                 timer_a_output,
	input  wire                 timer_b_output,
	output reg                  timer_a_input,
	output reg                  timer_b_input,
	input  wire                 i2c_a_enable,
	input  wire                 i2c_b_enable,
	input  wire                 i2c_a_clock_low,
	input  wire                 i2c_a_data_low,
	input  wire                 i2c_b_clock_low,
	input  wire                 i2c_b_data_low
);

	// Register state
	reg  [`PORT_W-1:0]  port_e_direction_q;
	reg  [`PORT_W-1:0]  port_e_output_value_q;
	reg  [`PORT_W-1:0]  port_e_driver_type_q;
	reg  [`PORT_W-1:0]  port_f_direction_q;
	reg  [`PORT_W-1:0]  port_f_output_value_q;
	reg  [`PORT_W-1:0]  port_f_driver_type_q;
	reg  [`PORT_W-1:0]  port_g_direction_q;
	reg  [`PORT_W-1:0]  port_g_output_value_q;

	// Write channel holding state
	reg                 aw_held_q;
	reg                 w_held_q;
	reg  [`ADDR_W-1:0]  waddr_q;
	reg  [`DATA_W-1:0]  wdata_q;
	reg  [3:0]          wstrb_q;

	wire                aw_take;
	wire                w_take;
	wire                ar_take;
	wire                do_write;
	wire                wr_hit;
	wire [`PORT_W-1:0]  wr_byte;

	// Timer and I2C takeover
	wire                timer_a_take;
	wire                timer_b_take;
	wire [`PORT_W-1:0]  pf_timer_take;
	wire [`PORT_W-1:0]  pf_timer_value;
	wire [`PORT_W-1:0]  pg_i2c_take;
	wire [`PORT_W-1:0]  pg_i2c_low;

	// Read mux
	reg  [`DATA_W-1:0]  rd_word;
	reg                 rd_ok;

	// Only the low byte lane carries register bits; the other lanes are ignored
	function [`PORT_W-1:0] merge_byte;
		input [`PORT_W-1:0] old_val;
		input [`DATA_W-1:0] data;
		input [3:0]         strb;
		begin
			if (strb[0]) begin
				merge_byte = data[`PORT_W-1:0];
			end else begin
				merge_byte = old_val;
			end
		end
	endfunction

	function [`DATA_W-1:0] zero_extend;
		input [`PORT_W-1:0] b;
		begin
			zero_extend = {{(`DATA_W-`PORT_W){1'b0}}, b};
		end
	endfunction

	function is_mapped;
		input [`ADDR_W-1:0] a;
		begin
			if (a == `OFF_PE_DIRECTION) begin
				is_mapped = 1'b1;
			end else if (a == `OFF_PE_OUTPUT_VALUE) begin
				is_mapped = 1'b1;
			end else if (a == `OFF_PE_DRIVER_TYPE) begin
				is_mapped = 1'b1;
			end else if (a == `OFF_PF_DIRECTION) begin
				is_mapped = 1'b1;
			end else if (a == `OFF_PF_OUTPUT_VALUE) begin
				is_mapped = 1'b1;
			end else if (a == `OFF_PF_DRIVER_TYPE) begin
				is_mapped = 1'b1;
			end else if (a == `OFF_PG_DIRECTION) begin
				is_mapped = 1'b1;
			end else if (a == `OFF_PG_OUTPUT_VALUE) begin
				is_mapped = 1'b1;
			end else begin
				is_mapped = 1'b0;
			end
		end
	endfunction

	assign aw_take  = s_axi_awvalid & s_axi_awready;
	assign w_take   = s_axi_wvalid & s_axi_wready;
	assign ar_take  = s_axi_arvalid & s_axi_arready;
	assign do_write = aw_held_q & w_held_q & ~s_axi_bvalid;
	assign wr_hit   = is_mapped(waddr_q);

	// Write address and data are taken in either order, one write at a time
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `RESP_OKAY;
			aw_held_q     <= 1'b0;
			w_held_q      <= 1'b0;
			waddr_q       <= `RST_BYTE;
			wdata_q       <= `RST_WORD;
			wstrb_q       <= `SEL_NONE;
		end else begin
			if (aw_take) begin
				aw_held_q     <= 1'b1;
				waddr_q       <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end else if (!aw_held_q && !s_axi_bvalid) begin
				s_axi_awready <= 1'b1;
			end
			if (w_take) begin
				w_held_q     <= 1'b1;
				wdata_q      <= s_axi_wdata;
				wstrb_q      <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end else if (!w_held_q && !s_axi_bvalid) begin
				s_axi_wready <= 1'b1;
			end
			if (do_write) begin
				aw_held_q    <= 1'b0;
				w_held_q     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	assign wr_byte = wdata_q[`PORT_W-1:0];

	// Register writes, committed in the cycle the response is raised
	always @(posedge aclk) begin
		if (!aresetn) begin
			port_e_direction_q    <= `RST_BYTE;
			port_e_output_value_q <= `RST_BYTE;
			port_e_driver_type_q  <= `RST_BYTE; // [R14]
			port_f_direction_q    <= `RST_BYTE;
			port_f_output_value_q <= `RST_BYTE;
			port_f_driver_type_q  <= `RST_BYTE; // [R14]
			port_g_direction_q    <= `RST_BYTE; // [R11]
			port_g_output_value_q <= `RST_BYTE;
		end else if (do_write) begin
			if (waddr_q == `OFF_PE_DIRECTION) begin
				port_e_direction_q <= merge_byte(port_e_direction_q, wdata_q, wstrb_q);
			end else if (waddr_q == `OFF_PE_OUTPUT_VALUE) begin
				port_e_output_value_q <= merge_byte(port_e_output_value_q, wdata_q, wstrb_q); // [R13]
			end else if (waddr_q == `OFF_PE_DRIVER_TYPE) begin
				port_e_driver_type_q <= merge_byte(port_e_driver_type_q, wdata_q, wstrb_q); // [R3]
			end else if (waddr_q == `OFF_PF_DIRECTION) begin
				port_f_direction_q <= merge_byte(port_f_direction_q, wdata_q, wstrb_q);
			end else if (waddr_q == `OFF_PF_OUTPUT_VALUE) begin
				port_f_output_value_q <= merge_byte(port_f_output_value_q, wdata_q, wstrb_q); // [R13]
			end else if (waddr_q == `OFF_PF_DRIVER_TYPE) begin
				port_f_driver_type_q <= merge_byte(port_f_driver_type_q, wdata_q, wstrb_q); // [R3]
			end else if (waddr_q == `OFF_PG_DIRECTION) begin
				// Only the full byte is meaningful, software keeps its own copy [R11] [R15]
				port_g_direction_q <= merge_byte(port_g_direction_q, wdata_q, wstrb_q);
			end else if (waddr_q == `OFF_PG_OUTPUT_VALUE) begin
				port_g_output_value_q <= merge_byte(port_g_output_value_q, wdata_q, wstrb_q);
			end
		end
	end

	// Read decode: direction addresses return the live pin levels
	always @* begin
		rd_word = `RST_WORD;
		rd_ok   = 1'b1;
		if (s_axi_araddr == `OFF_PE_DIRECTION) begin
			rd_word = zero_extend(pe_pin_in);
		end else if (s_axi_araddr == `OFF_PE_OUTPUT_VALUE) begin
			rd_word = zero_extend(port_e_output_value_q); // [R13]
		end else if (s_axi_araddr == `OFF_PE_DRIVER_TYPE) begin
			rd_word = zero_extend(port_e_driver_type_q);
		end else if (s_axi_araddr == `OFF_PF_DIRECTION) begin
			rd_word = zero_extend(pf_pin_in);
		end else if (s_axi_araddr == `OFF_PF_OUTPUT_VALUE) begin
			rd_word = zero_extend(port_f_output_value_q); // [R13]
		end else if (s_axi_araddr == `OFF_PF_DRIVER_TYPE) begin
			rd_word = zero_extend(port_f_driver_type_q);
		end else if (s_axi_araddr == `OFF_PG_DIRECTION) begin
			rd_word = zero_extend(pg_pin_in); // [R12]
		end else if (s_axi_araddr == `OFF_PG_OUTPUT_VALUE) begin
			rd_word = zero_extend(port_g_output_value_q);
		end else begin
			rd_ok   = 1'b0;
		end
	end

	// One read under way at a time; data registered at address acceptance
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= `RST_WORD;
			s_axi_rresp   <= `RESP_OKAY;
		end else begin
			if (ar_take) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid  <= 1'b1;
				s_axi_rdata   <= rd_word;
				s_axi_rresp   <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid  <= 1'b0;
				s_axi_arready <= 1'b1;
			end else if (!s_axi_rvalid) begin
				s_axi_arready <= 1'b1;
			end
		end
	end

	// Any nonzero select hands the pin to its timer [R1]
	assign timer_a_take = (timer_a_output_select != `SEL_NONE);
	assign timer_b_take = (timer_b_output_select != `SEL_NONE);

	// Bits 1 and 0 are never taken, so they follow direction alone [R2]
	assign pf_timer_take  = {{(`PORT_W-`PF_TIMER_B_OUT_BIT-1){1'b0}}, timer_b_take, timer_a_take,
				 2'b00};
	assign pf_timer_value = {{(`PORT_W-`PF_TIMER_B_OUT_BIT-1){1'b0}}, timer_b_output, timer_a_output,
				 2'b00};

	assign pg_i2c_take = {i2c_b_enable, i2c_b_enable, i2c_a_enable, i2c_a_enable, 4'h0}; // [R9]
	assign pg_i2c_low  = {i2c_b_clock_low, i2c_b_data_low, i2c_a_clock_low, i2c_a_data_low, 4'h0};

	pin_driver_port u_port_e (
		.aclk         (aclk),
		.aresetn      (aresetn),
		.hw_standby   (hw_standby),
		.direction    (port_e_direction_q),
		.output_value (port_e_output_value_q),
		.driver_type  (port_e_driver_type_q),
		.timer_take   (`RST_BYTE),
		.timer_value  (`RST_BYTE),
		.pin_out      (pe_pin_out),
		.pin_oe       (pe_pin_oe),
		.pull_on      (pe_pullup)
	);

	// Timer outputs pass through the same driver-type logic [R6]
	pin_driver_port u_port_f (
		.aclk         (aclk),
		.aresetn      (aresetn),
		.hw_standby   (hw_standby),
		.direction    (port_f_direction_q),
		.output_value (port_f_output_value_q),
		.driver_type  (port_f_driver_type_q),
		.timer_take   (pf_timer_take),
		.timer_value  (pf_timer_value),
		.pin_out      (pf_pin_out),
		.pin_oe       (pf_pin_oe),
		.pull_on      (pf_pullup)
	);

	port_g_driver u_port_g (
		.aclk         (aclk),
		.aresetn      (aresetn),
		.direction    (port_g_direction_q),
		.output_value (port_g_output_value_q),
		.i2c_take     (pg_i2c_take),
		.i2c_low      (pg_i2c_low),
		.pin_out      (pg_pin_out),
		.pin_oe       (pg_pin_oe)
	);

	// Timer inputs see the pin level whatever the direction [R2]
	always @(posedge aclk) begin
		if (!aresetn) begin
			timer_a_input <= 1'b0;
			timer_b_input <= 1'b0;
		end else begin
			timer_a_input <= pf_pin_in[`PF_TIMER_A_IN_BIT];
			timer_b_input <= pf_pin_in[`PF_TIMER_B_IN_BIT];
		end
	end

endmodule // gpio_drive_pullup_direction

/* gpio_drive_pullup_direction_assertions.sv */
/* Concurrent checks on the pin control block's top-level ports.
   Assumes one clock domain and a synchronous active-low reset. */
`timescale 1ns/1ps
`include "gpio_pin_defs.vh"
module gpio_drive_pullup_direction_assertions (
	input wire logic	aclk,
	input wire logic	aresetn,
	input wire logic [7:0]	s_axi_araddr,
	input wire logic	s_axi_arvalid,
	input wire logic	s_axi_arready,
	input wire logic [31:0]	s_axi_rdata,
	input wire logic	s_axi_rvalid,
	input wire logic	hw_standby,
	input wire logic [7:0]	pe_pin_oe,
	input wire logic [7:0]	pe_pullup,
	input wire logic [7:0]	pf_pin_in,
	input wire logic [7:0]	pf_pin_out,
	input wire logic [7:0]	pf_pin_oe,
	input wire logic [7:0]	pf_pullup,
	input wire logic [7:0]	pg_pin_in,
	input wire logic [7:0]	pg_pin_out,
	input wire logic [7:0]	pg_pin_oe,
	input wire logic [3:0]	timer_a_output_select,
	input wire logic [3:0]	timer_b_output_select,
	input wire logic	timer_a_output,
	input wire logic	timer_b_output,
	input wire logic	timer_a_input,
	input wire logic	timer_b_input,
	input wire logic	i2c_a_enable,
	input wire logic	i2c_b_enable,
	input wire logic	i2c_a_clock_low,
	input wire logic	i2c_a_data_low,
	input wire logic	i2c_b_clock_low,
	input wire logic	i2c_b_data_low
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Outputs still hold their reset values at the first edge after release, so $past(aresetn) guards
	a_pull_input_only: assert property (((pe_pullup & pe_pin_oe) | (pf_pullup & pf_pin_oe)) == 8'h00)
		else $error("pull-up on while pin driven");
	a_standby_pull_off: assert property ($past(hw_standby) |-> (pe_pullup | pf_pullup) == 8'h00)
		else $error("pull-up on in standby");
	a_timer_a_owns: assert property ($past(aresetn) && $past(|timer_a_output_select) |-> pf_pin_out[2] == $past(timer_a_output))
		else $error("timer a output not on pin");
	a_timer_b_owns: assert property ($past(aresetn) && $past(|timer_b_output_select) |-> pf_pin_out[3] == $past(timer_b_output) && ($past(timer_b_output) || pf_pin_oe[3]))
		else $error("timer b output not on pin");
	a_timer_in_copy: assert property ($past(aresetn) |-> {timer_b_input, timer_a_input} == $past(pf_pin_in[1:0]))
		else $error("timer input not following pin");
	a_i2c_a_open: assert property ($past(aresetn) && $past(i2c_a_enable) |-> pg_pin_out[5:4] == 2'h0 && pg_pin_oe[5:4] == $past({i2c_a_clock_low, i2c_a_data_low}))
		else $error("i2c a pins not open drain");
	a_i2c_b_open: assert property ($past(aresetn) && $past(i2c_b_enable) |-> pg_pin_out[7:6] == 2'h0 && pg_pin_oe[7:6] == $past({i2c_b_clock_low, i2c_b_data_low}))
		else $error("i2c b pins not open drain");
	a_dir_read_pins: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == `OFF_PG_DIRECTION |=> s_axi_rvalid && s_axi_rdata == {24'h0, $past(pg_pin_in)})
		else $error("direction read not pin levels");
	c_timer_take: cover property (|timer_a_output_select ##1 |timer_b_output_select);
	c_i2c_low: cover property (i2c_b_enable && i2c_b_clock_low);
	c_dir_read: cover property (s_axi_arvalid && s_axi_arready && s_axi_araddr == `OFF_PG_DIRECTION);
endmodule // gpio_drive_pullup_direction_assertions
bind gpio_drive_pullup_direction gpio_drive_pullup_direction_assertions chk_i (.*);

/* pad_model.sv */
/* Pad and board model for one 8-bit port.
   Assumes ext is reshuffled by the bench every step, so a floating pin never holds a stale level. */
`timescale 1ns/1ps
module pad_model (
	input wire logic [7:0]	drv_out,
	input wire logic [7:0]	drv_oe,
	input wire logic [7:0]	pull,
	input wire logic [7:0]	ext,
	output logic [7:0]	level
);
	// Driven pins win; a pulled pin reads high; otherwise the board decides
	assign level = (drv_oe & drv_out) | (~drv_oe & pull) | (~drv_oe & ~pull & ext);
endmodule // pad_model

/* gpio_drive_pullup_direction_tb.sv */
/* Self-checking bench: random register traffic and pin conditions against a register model.
   Assumes the design header and pad_model are compiled first. */
`timescale 1ns/1ps
`include "gpio_pin_defs.vh"
module gpio_drive_pullup_direction_tb;
	logic	aclk = 0, aresetn = 0, hw_standby = 0;
	logic [7:0]	s_axi_awaddr = '0, s_axi_araddr = '0, pe_ext = '0, pf_ext = '0, pg_ext = '0, tk, lo;
	logic [2:0]	s_axi_awprot = '0, s_axi_arprot = '0;
	logic [31:0]	s_axi_wdata = '0, s_axi_rdata, seed = 32'h19, d;
	logic [3:0]	s_axi_wstrb = 4'hf, timer_a_output_select = '0, timer_b_output_select = '0;
	logic	s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic	timer_a_output = 0, timer_b_output = 0, i2c_a_enable = 0, i2c_b_enable = 0;
	logic	i2c_a_clock_low = 0, i2c_a_data_low = 0, i2c_b_clock_low = 0, i2c_b_data_low = 0;
	logic	s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, timer_a_input, timer_b_input;
	logic [1:0]	s_axi_bresp, s_axi_rresp, r;
	logic [7:0]	pe_pin_out, pe_pin_oe, pe_pullup, pf_pin_out, pf_pin_oe, pf_pullup, pg_pin_out, pg_pin_oe;
	wire [7:0]	pe_pin_in, pf_pin_in, pg_pin_in;
	logic [7:0]	rg [8]; // Shadow of every register, direction ones included
	int	mismatches = 0, checked = 0, k;
	always #5 aclk = ~aclk;
	gpio_drive_pullup_direction dut (.*);
	pad_model pad_e (.drv_out(pe_pin_out), .drv_oe(pe_pin_oe), .pull(pe_pullup), .ext(pe_ext), .level(pe_pin_in));
	pad_model pad_f (.drv_out(pf_pin_out), .drv_oe(pf_pin_oe), .pull(pf_pullup), .ext(pf_ext), .level(pf_pin_in));
	pad_model pad_g (.drv_out(pg_pin_out), .drv_oe(pg_pin_oe), .pull(8'h00), .ext(pg_ext), .level(pg_pin_in));
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// Expected {out, oe, pullup} of port E or F
	function automatic logic [23:0] efx(input logic [7:0] dr, od, ty, tt, tv);
		logic [7:0] di, v;
		di = tt | dr;
		v = (tt & tv) | (~tt & od);
		return {v, di & (~v | ~ty), {8{~hw_standby}} & ~dr & od & ~di};
	endfunction
	task automatic complete_run();
		if (mismatches == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic tmo(input int n);
		if (n >= 50) begin
			mismatches++;
			$display("ERROR %0t: handshake wait ran out", $time);
			complete_run();
		end
	endtask
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
		int n;
		bit pa, pw;
		n = 0;
		pa = 1;
		pw = 1;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		while ((pa || pw) && n < 50) begin
			@(posedge aclk);
			n++;
			if (pa && s_axi_awready) begin
				pa = 0;
				s_axi_awvalid <= 0;
			end
			if (pw && s_axi_wready) begin
				pw = 0;
				s_axi_wvalid <= 0;
			end
		end
		s_axi_bready <= 1;
		do begin
			@(posedge aclk);
			n++;
		end while (!s_axi_bvalid && n < 50);
		resp = s_axi_bresp;
		s_axi_bready <= 0;
		tmo(n);
	endtask
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
		int n;
		n = 0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		do begin
			@(posedge aclk);
			n++;
		end while (!s_axi_arready && n < 50);
		s_axi_arvalid <= 0;
		while (!s_axi_rvalid && n < 50) begin
			@(posedge aclk);
			n++;
		end
		v = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 0;
		tmo(n);
	endtask
	task automatic check_pins();
		tk = {4'h0, |timer_b_output_select, |timer_a_output_select, 2'h0};
		chk({pe_pin_out, pe_pin_oe, pe_pullup}, efx(rg[0], rg[1], rg[2], 8'h00, 8'h00));
		chk({pf_pin_out, pf_pin_oe, pf_pullup}, efx(rg[3], rg[4], rg[5], tk, {4'h0, timer_b_output, timer_a_output, 2'h0}));
		tk = {{2{i2c_b_enable}}, {2{i2c_a_enable}}, 4'h0};
		lo = {i2c_b_clock_low, i2c_b_data_low, i2c_a_clock_low, i2c_a_data_low, 4'h0};
		chk({pg_pin_out, pg_pin_oe}, {~tk & rg[7], (tk & lo) | (~tk & rg[6])});
		chk({timer_b_input, timer_a_input}, pf_pin_in[1:0]);
	endtask
	initial begin
		for (k = 0; k < 8; k++)
			rg[k] = 8'h00;
		repeat (16) @(posedge aclk);
		chk({pe_pullup, pf_pullup, pg_pin_oe}, 32'h0);
		aresetn <= 1;
		repeat (2) @(posedge aclk);
		check_pins();
		for (k = 2; k < 8; k += 3) begin
			axi_rd(8'(k * 4), d, r);
			chk(d, 32'h0);
		end
		// Address 0x20 is the unmapped case, picked one time in nine
		repeat (80) begin
			k = rnd() % 9;
			d = rnd();
			// Low lane dropped one time in four; the port G direction always gets whole bytes
			s_axi_wstrb <= {3'h7, (|d[31:30]) || k == 6};
			axi_wr(8'(k * 4), d, r);
			chk(r, k == 8 ? `RESP_SLVERR : `RESP_OKAY);
			if (k < 8 && ((|d[31:30]) || k == 6))
				rg[k] = d[7:0];
			@(posedge aclk);
			d = rnd();
			pe_ext <= d[7:0];
			pf_ext <= d[15:8];
			pg_ext <= d[23:16];
			hw_standby <= d[24] & d[25];
			d = rnd();
			timer_a_output_select <= d[3:0] & {4{d[4]}};
			timer_b_output_select <= d[8:5] & {4{d[9]}};
			{timer_b_output, timer_a_output, i2c_b_enable, i2c_a_enable} <= d[13:10];
			{i2c_b_clock_low, i2c_b_data_low, i2c_a_clock_low, i2c_a_data_low} <= d[17:14];
			repeat (3) @(posedge aclk);
			check_pins();
			k = rnd() % 9;
			axi_rd(8'(k * 4), d, r);
			chk(r, k == 8 ? `RESP_SLVERR : `RESP_OKAY);
			case (k)
				0: lo = pe_pin_in;
				3: lo = pf_pin_in;
				6: lo = pg_pin_in;
				8: lo = 8'h00;
				default: lo = rg[k];
			endcase
			chk(d, {24'h0, lo});
		end
		complete_run();
	end
endmodule // gpio_drive_pullup_direction_tb
